// ---- test_port.sv ----
// test port, probe bus view and self-check control with an apb slave
// Notes on behaviour
// - each of six drive-enable bits enables the driver of one data pin.
// - uart line enable zero disables the multiplexed out and request lines.
// - io select set with serial host runs the port as general io.
// - in io mode enabled pins drive the stored pin-level bits.
// - pin-level read returns live pins when io select set, else stored value.
// - read-only eight-bit register shows the internal probe bus as sampled one clock earlier.
// - self-check enabled once the four-bit code equals 1001b, and stays enabled while it runs until done.
// - checksum command starts the self-check once enabled.
// - nonlinear receive bit set makes the receiver chain nonlinear.
// - thresholds act nonlinearly while nonlinear receive is active.
// - a five-bit select field chooses the probe bus signal group.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module test_port
    import test_port_pkg::*;
#(
    parameter int PINS = 6
) (
    input wire logic clock_i,                        // 40 mhz clock
    input wire logic sys_rst_i,                      // sync reset, high
    input wire logic psel,                           // apb select
    input wire logic penable,                        // apb enable
    input wire logic pwrite,                         // apb direction
    input wire logic [11:0] paddr,                   // apb byte address
    input wire logic [31:0] pwdata,                  // apb write data
    output logic [31:0] prdata,                      // apb read data
    output logic pready,                             // apb ready
    output logic pslverr,                            // apb error
    input wire logic [PINS-1:0] pin_in_i,            // data pins d6..d1 level
    output test_port_pkg::pin_drive_s pin_drive_o,   // pin levels and enables
    input wire logic [PROBE_W-1:0] probe_bus_i,      // selected probe group
    output logic [PROBE_SEL_W-1:0] probe_select_o,   // probe group choice
    input wire logic uart_mux_out_i,                 // uart mux data source
    input wire logic uart_request_i,                 // uart request source
    output logic uart_multiplexed_out_o,             // gated mux line
    output logic uart_request_line_o,                // gated request line
    output logic uart_line_en_o,                     // uart aux lines enabled
    input wire logic checksum_calculate_cmd_i,       // checksum command pulse
    input wire logic self_check_done_i,              // self-check finished
    output logic self_check_enable_o,                // armed by enable pattern, or running
    output logic self_check_start_o,                 // one-cycle start pulse
    output logic self_check_busy_o,                  // sequence running
    output logic nonlinear_receive_o,                // nonlinear rx path
    output logic nonlinear_threshold_o               // nonlinear thresholds
);
    typedef struct packed {
        logic [7:0] pin_en;
        logic [7:0] pin_lvl;
        logic [7:0] ctrl;
        logic [PROBE_SEL_W-1:0] psel_f;
        logic [1:0] host;
        check_state_e st;
        logic [31:0] rdata;
        logic ready;
        logic err;
        pin_drive_s drive;
        logic mx;
        logic rq;
        logic start;
    } state_s;

    state_s q, d;
    logic [PROBE_W-1:0] probe_view;
    logic serial_host;
    logic io_mode;
    logic [7:0] idx;
    logic wr, rd, acc;

    probe_sample #(
        .WIDTH(PROBE_W)
    ) u_probe (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .data_i(probe_bus_i),
        .data_o(probe_view)
    );

    assign serial_host = (q.host != HOST_PARALLEL);
    assign io_mode = q.pin_lvl[PORT_IO_SEL_BIT] & serial_host;
    assign idx = paddr[9:2];
    assign acc = psel & penable & ~q.ready;

    always_comb begin
        d = q;
        d.ready = 1'b0;
        d.err = 1'b0;
        d.start = 1'b0;
        wr = acc & pwrite;
        rd = acc & ~pwrite;
        if (acc) begin
            d.ready = 1'b1;
        end
        if (wr && paddr[1:0] == 2'h0 && idx == IDX_PIN_DRIVE_ENABLE) begin
            d.pin_en = pwdata[7:0] & WMASK_PIN_REG;
        end else if (wr && paddr[1:0] == 2'h0 && idx == IDX_PIN_LEVEL) begin
            d.pin_lvl = pwdata[7:0] & WMASK_PIN_REG;
        end else if (wr && paddr[1:0] == 2'h0 && idx == IDX_SELF_CHECK_CONTROL) begin
            d.ctrl = (q.ctrl & ~WMASK_SELF_CHECK) | (pwdata[7:0] & WMASK_SELF_CHECK);
        end else if (wr && paddr[1:0] == 2'h0 && idx == IDX_PROBE_SELECT) begin
            d.psel_f = pwdata[PROBE_SEL_W-1:0];
        end else if (wr && paddr[1:0] == 2'h0 && idx == IDX_HOST_MODE) begin
            d.host = pwdata[1:0];
        end else if (wr && (paddr[1:0] != 2'h0 || idx != IDX_PROBE_BUS_VIEW)) begin
            d.err = 1'b1;
        end
        if (rd) begin
            d.rdata = 32'h0000_0000;
            if (paddr[1:0] != 2'h0) begin
                d.err = 1'b1;
            end else if (idx == IDX_PIN_DRIVE_ENABLE) begin
                d.rdata[7:0] = q.pin_en;
            end else if (idx == IDX_PIN_LEVEL) begin
                if (q.pin_lvl[PORT_IO_SEL_BIT]) begin
                    d.rdata[7:0] = {q.pin_lvl[PORT_IO_SEL_BIT], pin_in_i, 1'b0};
                end else begin
                    d.rdata[7:0] = q.pin_lvl;
                end
            end else if (idx == IDX_PROBE_BUS_VIEW) begin
                d.rdata[7:0] = probe_view;
            end else if (idx == IDX_SELF_CHECK_CONTROL) begin
                d.rdata[7:0] = q.ctrl;
            end else if (idx == IDX_PROBE_SELECT) begin
                d.rdata[PROBE_SEL_W-1:0] = q.psel_f;
            end else if (idx == IDX_HOST_MODE) begin
                d.rdata[1:0] = q.host;
            end else begin
                d.err = 1'b1;
            end
        end
        d.drive.oe_n = ~q.pin_en[PIN_FIELD_MSB:PIN_FIELD_LSB];
        if (io_mode) begin
            d.drive.out = q.pin_lvl[PIN_FIELD_MSB:PIN_FIELD_LSB];
        end else begin
            d.drive.out = probe_view[PINS-1:0];
        end
        d.mx = q.pin_en[UART_LINE_EN_BIT] & uart_mux_out_i;
        d.rq = q.pin_en[UART_LINE_EN_BIT] & uart_request_i;
        case (q.st)
            ST_IDLE: begin
                if (q.ctrl[CODE_MSB:0] == SELF_CHECK_ENABLE_CODE) begin
                    d.st = ST_ARMED;
                end
            end
            ST_ARMED: begin
                if (q.ctrl[CODE_MSB:0] != SELF_CHECK_ENABLE_CODE) begin
                    d.st = ST_IDLE;
                end else if (checksum_calculate_cmd_i) begin
                    d.st = ST_RUN;
                    d.start = 1'b1;
                end
            end
            ST_RUN: begin
                if (self_check_done_i) begin
                    d.st = ST_IDLE;
                end
            end
            default: begin
                d.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            q.pin_en <= RST_PIN_DRIVE_ENABLE;
            q.pin_lvl <= RST_PIN_LEVEL;
            q.ctrl <= RST_SELF_CHECK_CONTROL;
            q.psel_f <= RST_PROBE_SELECT;
            q.host <= RST_HOST_MODE;
            q.st <= ST_IDLE;
            q.rdata <= 32'h0000_0000;
            q.ready <= 1'b0;
            q.err <= 1'b0;
            q.drive.out <= '0;
            q.drive.oe_n <= '1;
            q.mx <= 1'b0;
            q.rq <= 1'b0;
            q.start <= 1'b0;
        end else begin
            q <= d;
        end
    end

    assign prdata = q.rdata;
    assign pready = q.ready;
    assign pslverr = q.err;
    assign pin_drive_o = q.drive;
    assign probe_select_o = q.psel_f;
    assign uart_multiplexed_out_o = q.mx;
    assign uart_request_line_o = q.rq;
    assign uart_line_en_o = q.pin_en[UART_LINE_EN_BIT];
    assign self_check_enable_o = (q.st != ST_IDLE);
    assign self_check_start_o = q.start;
    assign self_check_busy_o = (q.st == ST_RUN);
    assign nonlinear_receive_o = q.ctrl[NONLINEAR_BIT];
    assign nonlinear_threshold_o = q.ctrl[NONLINEAR_BIT];
endmodule : test_port
`default_nettype wire

// ---- test_port_pkg.sv ----
// shared constants and carrier types for the test-port block
package test_port_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_PIN_DRIVE_ENABLE = 8'h33;
    localparam logic [7:0] IDX_PIN_LEVEL = 8'h34;
    localparam logic [7:0] IDX_PROBE_BUS_VIEW = 8'h35;
    localparam logic [7:0] IDX_SELF_CHECK_CONTROL = 8'h36;
    localparam logic [7:0] IDX_PROBE_SELECT = 8'h40;
    localparam logic [7:0] IDX_HOST_MODE = 8'h41;
    localparam logic [7:0] RST_PIN_DRIVE_ENABLE = 8'h80;
    localparam logic [7:0] RST_PIN_LEVEL = 8'h00;
    localparam logic [7:0] RST_SELF_CHECK_CONTROL = 8'h40;
    localparam logic [4:0] RST_PROBE_SELECT = 5'h00;
    localparam logic [1:0] RST_HOST_MODE = 2'h0;
    // field positions
    localparam int UART_LINE_EN_BIT = 7;
    localparam int PORT_IO_SEL_BIT = 7;
    localparam int PIN_FIELD_LSB = 1;
    localparam int PIN_FIELD_MSB = 6;
    localparam int NONLINEAR_BIT = 6;
    localparam int CODE_MSB = 3;
    // masks of software-writable bits
    localparam logic [7:0] WMASK_PIN_REG = 8'hfe;
    localparam logic [7:0] WMASK_SELF_CHECK = 8'h4f;
    localparam logic [3:0] SELF_CHECK_ENABLE_CODE = 4'h9;
    localparam int PIN_COUNT = 6;
    localparam int PROBE_SEL_W = 5;
    localparam int PROBE_W = 8;

    typedef enum logic [1:0] {
        HOST_PARALLEL = 2'h0,
        HOST_SPI = 2'h1,
        HOST_UART = 2'h2,
        HOST_I2C = 2'h3
    } host_mode_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ARMED = 3'b010,
        ST_RUN = 3'b100
    } check_state_e;

    typedef struct packed {
        logic [PIN_COUNT-1:0] out;
        logic [PIN_COUNT-1:0] oe_n;
    } pin_drive_s;

    typedef struct packed {
        logic [PROBE_SEL_W-1:0] sel;
        logic [PROBE_W-1:0] value;
    } probe_s;
endpackage : test_port_pkg

// ---- probe_sample.sv ----
// registered sampler for the internal probe bus
`timescale 1ns/1ps
`default_nettype none
module probe_sample #(
    parameter int WIDTH = 8
) (
    input wire logic clock_i,            // system clock
    input wire logic sys_rst_i,          // sync reset
    input wire logic [WIDTH-1:0] data_i, // live bus
    output logic [WIDTH-1:0] data_o      // sampled bus
);
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            data_o <= '0;
        end else begin
            data_o <= data_i;
        end
    end
endmodule : probe_sample
`default_nettype wire

// ---- test_port_chk.sv ----
// assertion checker for the test port block
`timescale 1ns/1ps
`default_nettype none
module test_port_chk
    import test_port_pkg::*;
#(
    parameter int PINS = 6
) (
    input wire logic clock_i, // clock
    input wire logic sys_rst_i, // reset
    input wire logic psel, // apb
    input wire logic penable, // apb
    input wire logic pwrite, // apb
    input wire logic [31:0] pwdata, // apb
    input wire logic pready, // apb
    input wire logic pslverr, // apb
    input wire test_port_pkg::pin_drive_s pin_drive_o, // pins
    input wire logic uart_multiplexed_out_o, // uart
    input wire logic uart_request_line_o, // uart
    input wire logic uart_line_en_o, // uart
    input wire logic checksum_calculate_cmd_i, // command
    input wire logic self_check_done_i, // done
    input wire logic self_check_enable_o, // armed
    input wire logic self_check_start_o, // start
    input wire logic nonlinear_receive_o, // rx
    input wire logic nonlinear_threshold_o // thresholds
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (sys_rst_i);
    chk_ready_pulse:
        assert property (pready |=> !pready) else $error("ready held too long");
    chk_ready_wait:
        assert property ($rose(penable) && psel |=> pready) else $error("no answer after one wait");
    chk_err_ready:
        assert property (pslverr |-> pready) else $error("error without ready");
    chk_uart_gate:
        assert property (!uart_line_en_o && !$past(uart_line_en_o) |-> !uart_multiplexed_out_o && !uart_request_line_o)
            else $error("uart lines active while disabled");
    chk_oe_write:
        assert property ($changed(pin_drive_o.oe_n) |-> $past(psel && pwrite)) else $error("driver moved unasked");
    chk_arm_code:
        assert property ($rose(self_check_enable_o) |-> $past(pwdata[3:0]) == 4'h9 || $past(pwdata[3:0], 2) == 4'h9
            || $past(self_check_done_i) || $past(self_check_done_i, 2)) else $error("armed without code");
    chk_start_cause:
        assert property (self_check_start_o |-> $past(checksum_calculate_cmd_i && self_check_enable_o))
            else $error("start without armed command");
    chk_start_pulse:
        assert property (self_check_start_o |=> !self_check_start_o) else $error("start pulse too long");
    chk_nl_write:
        assert property ($changed(nonlinear_receive_o) |-> $past(psel && pwrite)) else $error("rx mode moved unasked");
    chk_nl_pair:
        assert property (nonlinear_threshold_o == nonlinear_receive_o) else $error("thresholds differ from rx");
    cov_start: cover property (self_check_start_o);
    cov_error: cover property (pslverr);
    cov_drive: cover property (!pin_drive_o.oe_n[5]);
endmodule : test_port_chk
bind test_port test_port_chk #(.PINS(PINS)) u_chk (.clock_i, .sys_rst_i, .psel, .penable, .pwrite, .pwdata, .pready,
    .pslverr, .pin_drive_o, .uart_multiplexed_out_o, .uart_request_line_o, .uart_line_en_o, .checksum_calculate_cmd_i,
    .self_check_done_i, .self_check_enable_o, .self_check_start_o, .nonlinear_receive_o, .nonlinear_threshold_o);
`default_nettype wire

// ---- pin_equipment.sv ----
// model of the test equipment on the data pins
`timescale 1ns/1ps
`default_nettype none
module pin_equipment
    import test_port_pkg::*;
(
    input wire test_port_pkg::pin_drive_s drive_i, // device drive
    input wire logic [PIN_COUNT-1:0] level_i, // equipment level
    output logic [PIN_COUNT-1:0] pin_o // pin level seen
);
    // device owns enabled pins, equipment the rest
    assign pin_o = (~drive_i.oe_n & drive_i.out) | (drive_i.oe_n & level_i);
endmodule : pin_equipment
`default_nettype wire

// ---- test_port_tb.sv ----
// self-checking testbench for the test port block
`timescale 1ns/1ps
`default_nettype none
module test_port_tb;
    import test_port_pkg::*;
    logic clock_i = 0, sys_rst_i = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic mux = 0, req = 0, cmd = 0, done = 0, umx, urq, uen, sce, scs, scb, nlr, nlt;
    logic [5:0] ext = 0, pin_in, out_e;
    logic [7:0] probe = 0, en = 8'h80, lv = 0, sc = 8'h40, dd;
    logic [4:0] sel = 0, grp;
    logic [1:0] host = 0;
    pin_drive_s drv;
    int failures = 0, tests_run = 0, seed = 32'h8c35;
    always #12.5 clock_i = ~clock_i;
    test_port #(.PINS(6)) uut (.clock_i, .sys_rst_i, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .pin_in_i(pin_in), .pin_drive_o(drv), .probe_bus_i(probe), .probe_select_o(grp),
        .uart_mux_out_i(mux), .uart_request_i(req), .uart_multiplexed_out_o(umx), .uart_request_line_o(urq),
        .uart_line_en_o(uen), .checksum_calculate_cmd_i(cmd), .self_check_done_i(done), .self_check_enable_o(sce),
        .self_check_start_o(scs), .self_check_busy_o(scb), .nonlinear_receive_o(nlr), .nonlinear_threshold_o(nlt));
    pin_equipment peq (.drive_i(drv), .level_i(ext), .pin_o(pin_in));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
        int n;
        n = 0;
        @(posedge clock_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock_i);
        penable <= 1'b1;
        do @(posedge clock_i); while (pready !== 1'b1 && ++n < 20);
        chk(pready, 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk(er, e);
    endtask : apb
    task wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d}, 1'b0);
        case (a)
            12'h0cc: en = d & 8'hfe;
            12'h0d0: lv = d & 8'hfe;
            12'h0d8: sc = d & 8'h4f;
            12'h100: sel = d[4:0];
            12'h104: host = d[1:0];
            default: ;
        endcase
    endtask : wr
    task rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 1'b0);
        chk(rd, exp);
    endtask : rdc
    task pulse(input logic exp);
        repeat (2) @(posedge clock_i);
        cmd <= 1'b1;
        @(posedge clock_i);
        cmd <= 1'b0;
        #1 chk(scs, exp);
        @(posedge clock_i);
        #1 chk({scs, scb}, {1'b0, exp});
    endtask : pulse
    task end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        #200000;
        failures++;
        end_of_test;
    end
    initial begin
        repeat (4) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        #1 chk({drv.oe_n, uen, nlr, nlt, sce, scs, scb}, {6'h3f, 6'b111000});
        chk({pready, pslverr, umx, urq, grp}, 9'h000);
        rdc(12'h0cc, 32'h80);
        rdc(12'h0d0, 32'h0);
        rdc(12'h0d8, 32'h40);
        $display("test reset done");
        for (int i = 0; i < 40; i++) begin
            @(posedge clock_i);
            probe <= $random(seed);
            ext <= $random(seed);
            mux <= $random(seed);
            req <= $random(seed);
            dd = $random(seed);
            case (i % 6)
                0: wr(12'h0cc, (host == 1 || (host == 2 && dd[7])) ? dd & 8'h9f : dd);
                1: wr(12'h0d0, dd);
                2: wr(12'h0d8, dd & 8'h4f);
                3: wr(12'h100, dd);
                // high pins already enabled keep the host off spi and line-enabled uart
                4: wr(12'h104, (en[6:5] != 2'h0 && (dd[1:0] == 2'h1 || (dd[1:0] == 2'h2 && en[7])))
                    ? dd & 8'hfc : dd);
                default: wr(12'h0d4, dd);
            endcase
            repeat (3) @(posedge clock_i);
            #1 out_e = (lv[7] && host != 0) ? lv[6:1] : probe[5:0];
            chk(drv.oe_n, 6'(~en[6:1]));
            chk(drv.out, out_e);
            chk({uen, umx, urq}, {en[7], en[7] & mux, en[7] & req});
            chk(grp, sel);
            chk(sce, sc[3:0] == 4'h9);
            chk({nlr, nlt}, {2{sc[6]}});
            rdc(12'h0d0, lv[7] ? {24'h0, 1'b1, (en[6:1] & out_e) | (~en[6:1] & ext), 1'b0} : lv);
            rdc(12'h0d4, probe);
            rdc(12'h0cc, en);
            rdc(12'h0d8, sc);
        end
        $display("test random registers done");
        apb(1'b1, 12'h0c8, 32'hff, 1'b1);
        apb(1'b1, 12'h0cd, 32'hff, 1'b1);
        apb(1'b1, 12'h0d5, 32'hff, 1'b1);
        rdc(12'h0cc, en);
        $display("test refused access done");
        wr(12'h0d8, 8'h48);
        pulse(1'b0);
        wr(12'h0d8, 8'h49);
        pulse(1'b1);
        @(posedge clock_i);
        done <= 1'b1;
        @(posedge clock_i);
        done <= 1'b0;
        repeat (2) @(posedge clock_i);
        #1 chk(scb, 1'b0);
        wr(12'h0d8, 8'h40);
        repeat (3) @(posedge clock_i);
        #1 chk(sce, 1'b0);
        $display("test self check done");
        end_of_test;
    end
endmodule : test_port_tb
`default_nettype wire
